// file: logic/bus_port_pkg.sv
// Shared constants and types for the quad UART parallel bus port
package bus_port_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned CHANS = 4;
  localparam int unsigned CHAN_W = 2;
  localparam int unsigned REGS = 8;
  localparam logic [ADDR_W-1:0] MODEM_CTRL_ADDR = 3'h4;
  localparam int unsigned IRQ_EN_BIT = 3;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic STYLE_STROBE = 1'h1;
  localparam logic DIR_READ = 1'h1;
  localparam int unsigned HOST_PHASE_CYC = 2;
  typedef logic [DATA_W-1:0] byte_t;
endpackage

// file: logic/bus_port_if.sv
// Pin-level carrier between the host and the quad UART bus port
`timescale 1ns/1ns
interface bus_port_if;
  logic style_strobe;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan_a_select_n;
  logic chan_b_select_n;
  logic chan_c_select_n;
  logic chan_d_select_n;
  logic [bus_port_pkg::ADDR_W-1:0] addr;
  bus_port_pkg::byte_t data_host;
  logic data_host_oe;
  bus_port_pkg::byte_t data_dev;
  logic data_dev_oe;
  logic chan_a_irq_out;
  logic chan_a_irq_oe;
  logic chan_b_irq_out;
  logic chan_c_irq_out;
  logic chan_d_irq_out;
  modport device (
    input style_strobe, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
    input chan_c_select_n, chan_d_select_n, addr, data_host, data_host_oe,
    output data_dev, data_dev_oe, chan_a_irq_out, chan_a_irq_oe,
    output chan_b_irq_out, chan_c_irq_out, chan_d_irq_out
  );
  modport host (
    output style_strobe, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
    output chan_c_select_n, chan_d_select_n, addr, data_host, data_host_oe,
    input data_dev, data_dev_oe, chan_a_irq_out, chan_a_irq_oe,
    input chan_b_irq_out, chan_c_irq_out, chan_d_irq_out
  );
endinterface

// file: logic/uart_bus_port.sv
// Device end: decodes host bus accesses into a four-channel register file
`timescale 1ns/1ns
module uart_bus_port (
  input wire logic clk,
  input wire logic sys_rst,
  bus_port_if.device bus,
  input wire logic [bus_port_pkg::CHANS-1:0] chan_irq,
  output logic wr_commit,
  output logic [bus_port_pkg::CHAN_W-1:0] wr_chan,
  output logic [bus_port_pkg::ADDR_W-1:0] wr_addr,
  output bus_port_pkg::byte_t wr_data
);
  typedef struct packed {
    logic rd_n_prev;
    logic wr_n_prev;
    logic rd_active;
    logic wr_active;
    logic [bus_port_pkg::CHAN_W-1:0] chan;
    logic [bus_port_pkg::ADDR_W-1:0] addr;
    bus_port_pkg::byte_t [bus_port_pkg::CHANS*bus_port_pkg::REGS-1:0] regs;
    bus_port_pkg::byte_t dout;
    logic dout_oe;
    logic irq_a;
    logic irq_a_oe;
    logic irq_b;
    logic irq_c;
    logic irq_d;
    logic wr_commit;
    logic [bus_port_pkg::CHAN_W-1:0] wr_chan;
    logic [bus_port_pkg::ADDR_W-1:0] wr_addr;
    bus_port_pkg::byte_t wr_data;
  } dev_s;

  // ----------------------------------------------------------------
  // Reset image: strobes idle high, outputs quiet, registers cleared
  // ----------------------------------------------------------------
  localparam dev_s DEV_RESET = '{
    rd_n_prev: 1'b1,
    wr_n_prev: 1'b1,
    rd_active: 1'b0,
    wr_active: 1'b0,
    chan: '0,
    addr: '0,
    regs: {(bus_port_pkg::CHANS*bus_port_pkg::REGS){bus_port_pkg::REG_RESET}},
    dout: bus_port_pkg::REG_RESET,
    dout_oe: 1'b0,
    irq_a: 1'b0,
    irq_a_oe: 1'b0,
    irq_b: 1'b0,
    irq_c: 1'b0,
    irq_d: 1'b0,
    wr_commit: 1'b0,
    wr_chan: '0,
    wr_addr: '0,
    wr_data: bus_port_pkg::REG_RESET
  };

  dev_s st_q;
  dev_s st_d;
  logic strobe_mode;
  logic sel_any;
  logic [bus_port_pkg::CHAN_W-1:0] sel_chan;
  logic rd_req;
  logic wr_req;
  logic [bus_port_pkg::CHANS-1:0] irq_en;

  // ----------------------------------------------------------------
  // Channel enables from modem control bit 3
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < bus_port_pkg::CHANS; g++) begin : g_en
      assign irq_en[g] =
        st_q.regs[g*bus_port_pkg::REGS + bus_port_pkg::MODEM_CTRL_ADDR][bus_port_pkg::IRQ_EN_BIT];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus style decode
  // ----------------------------------------------------------------
  always_comb begin
    strobe_mode = (bus.style_strobe == bus_port_pkg::STYLE_STROBE);
    sel_any = 1'b0;
    sel_chan = '0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    if (strobe_mode) begin
      // Lowest active select wins if several are low
      if (!bus.chan_d_select_n) begin
        sel_any = 1'b1;
        sel_chan = 2'h3;
      end
      if (!bus.chan_c_select_n) begin
        sel_any = 1'b1;
        sel_chan = 2'h2;
      end
      if (!bus.chan_b_select_n) begin
        sel_any = 1'b1;
        sel_chan = 2'h1;
      end
      if (!bus.chan_a_select_n) begin
        sel_any = 1'b1;
        sel_chan = 2'h0;
      end
      rd_req = sel_any && !bus.read_strobe_n;
      wr_req = sel_any && !bus.write_strobe_n;
    end else begin
      // Read strobe and channel D select are not looked at here
      sel_any = !bus.chan_a_select_n;
      sel_chan = {bus.chan_c_select_n, bus.chan_b_select_n};
      rd_req = sel_any && (bus.write_strobe_n == bus_port_pkg::DIR_READ);
      wr_req = sel_any && (bus.write_strobe_n != bus_port_pkg::DIR_READ);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.wr_commit = 1'b0;
    st_d.rd_n_prev = bus.read_strobe_n;
    st_d.wr_n_prev = bus.write_strobe_n;
    if (strobe_mode) begin
      if (rd_req && st_q.rd_n_prev) begin
        st_d.rd_active = 1'b1;
        st_d.chan = sel_chan;
        st_d.addr = bus.addr;
      end else if (bus.read_strobe_n) begin
        st_d.rd_active = 1'b0;
      end
      if (wr_req && st_q.wr_n_prev) begin
        st_d.wr_active = 1'b1;
        st_d.chan = sel_chan;
        st_d.addr = bus.addr;
      end
      // Data taken on the rising write strobe
      if (st_q.wr_active && bus.write_strobe_n) begin
        st_d.wr_active = 1'b0;
        st_d.regs[{st_q.chan, st_q.addr}] = bus.data_host;
        st_d.wr_commit = 1'b1;
        st_d.wr_chan = st_q.chan;
        st_d.wr_addr = st_q.addr;
        st_d.wr_data = bus.data_host;
      end
    end else begin
      st_d.rd_active = rd_req;
      if (rd_req || wr_req) begin
        st_d.chan = sel_chan;
        st_d.addr = bus.addr;
      end
      if (wr_req) begin
        st_d.wr_active = 1'b1;
      end
      // Write taken when chip select rises after a write phase
      if (st_q.wr_active && !wr_req) begin
        st_d.wr_active = 1'b0;
        st_d.regs[{st_q.chan, st_q.addr}] = bus.data_host;
        st_d.wr_commit = 1'b1;
        st_d.wr_chan = st_q.chan;
        st_d.wr_addr = st_q.addr;
        st_d.wr_data = bus.data_host;
      end
    end
    // Read data follows the latched register while the read stands
    st_d.dout_oe = st_d.rd_active;
    st_d.dout = st_d.regs[{st_d.chan, st_d.addr}];
    if (strobe_mode) begin
      st_d.irq_a = chan_irq[0];
      st_d.irq_a_oe = irq_en[0];
      st_d.irq_b = chan_irq[1];
      st_d.irq_c = chan_irq[2];
      st_d.irq_d = chan_irq[3];
    end else begin
      st_d.irq_a = 1'b0;
      st_d.irq_a_oe = |(chan_irq & irq_en);
      st_d.irq_b = 1'b0;
      st_d.irq_c = 1'b0;
      st_d.irq_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= DEV_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin and side outputs
  // ----------------------------------------------------------------
  assign bus.data_dev = st_q.dout;
  assign bus.data_dev_oe = st_q.dout_oe;
  assign bus.chan_a_irq_out = st_q.irq_a;
  assign bus.chan_a_irq_oe = st_q.irq_a_oe;
  assign bus.chan_b_irq_out = st_q.irq_b;
  assign bus.chan_c_irq_out = st_q.irq_c;
  assign bus.chan_d_irq_out = st_q.irq_d;
  assign wr_commit = st_q.wr_commit;
  assign wr_chan = st_q.wr_chan;
  assign wr_addr = st_q.wr_addr;
  assign wr_data = st_q.wr_data;
endmodule // uart_bus_port

// file: logic/uart_bus_host.sv
// Host end: turns user requests into strobe or rw-line bus cycles
`timescale 1ns/1ns
module uart_bus_host (
  input wire logic clk,
  input wire logic sys_rst,
  bus_port_if.host bus,
  input wire logic style_strobe,
  input wire logic req,
  input wire logic req_write,
  input wire logic [bus_port_pkg::CHAN_W-1:0] req_chan,
  input wire logic [bus_port_pkg::ADDR_W-1:0] req_addr,
  input wire bus_port_pkg::byte_t req_wdata,
  output logic busy,
  output logic done,
  output bus_port_pkg::byte_t rdata
);
  typedef enum logic [2:0] {
    IDLE = 3'h1,
    ACT = 3'h2,
    REL = 3'h4
  } hstate_e;
  typedef struct packed {
    hstate_e state;
    logic [1:0] cnt;
    logic write;
    logic [bus_port_pkg::CHAN_W-1:0] chan;
    logic [bus_port_pkg::ADDR_W-1:0] addr;
    bus_port_pkg::byte_t wdata;
    logic rd_n;
    logic wr_n;
    logic [bus_port_pkg::CHANS-1:0] cs_n;
    logic oe;
    logic busy;
    logic done;
    bus_port_pkg::byte_t rdata;
  } host_s;

  host_s st_q;
  host_s st_d;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    unique case (st_q.state)
      IDLE: begin
        if (req) begin
          st_d.state = ACT;
          st_d.cnt = '0;
          st_d.write = req_write;
          st_d.chan = req_chan;
          st_d.addr = req_addr;
          st_d.wdata = req_wdata;
          st_d.busy = 1'b1;
          st_d.oe = req_write;
          if (style_strobe) begin
            st_d.cs_n = ~(4'h1 << req_chan);
            st_d.rd_n = req_write;
            st_d.wr_n = !req_write;
          end else begin
            // Spare read strobe and channel D select held active, the device ignores them
            st_d.cs_n = {1'b0, req_chan, 1'b0};
            st_d.rd_n = 1'b0;
            st_d.wr_n = !req_write;
          end
        end
      end
      ACT: begin
        st_d.cnt = st_q.cnt + 2'h1;
        if (st_q.cnt == 2'(bus_port_pkg::HOST_PHASE_CYC)) begin
          st_d.state = REL;
          if (!st_q.write) begin
            st_d.rdata = bus.data_dev;
          end
          st_d.rd_n = 1'b1;
          if (style_strobe) begin
            st_d.wr_n = 1'b1;
          end else begin
            st_d.cs_n[0] = 1'b1;
          end
        end
      end
      REL: begin
        st_d.state = IDLE;
        st_d.cs_n = '1;
        st_d.wr_n = 1'b1;
        st_d.oe = 1'b0;
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
      default: st_d.state = IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.state <= IDLE;
      st_q.rd_n <= 1'b1;
      st_q.wr_n <= 1'b1;
      st_q.cs_n <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.style_strobe = style_strobe;
  assign bus.read_strobe_n = st_q.rd_n;
  assign bus.write_strobe_n = st_q.wr_n;
  assign bus.chan_a_select_n = st_q.cs_n[0];
  assign bus.chan_b_select_n = st_q.cs_n[1];
  assign bus.chan_c_select_n = st_q.cs_n[2];
  assign bus.chan_d_select_n = st_q.cs_n[3];
  assign bus.addr = st_q.addr;
  assign bus.data_host = st_q.wdata;
  assign bus.data_host_oe = st_q.oe;
  assign busy = st_q.busy;
  assign done = st_q.done;
  assign rdata = st_q.rdata;
endmodule // uart_bus_host

// file: tb/bus_port_props.sv
// Concurrent checks on the bus carrier between host and device ends
`timescale 1ns/1ns
module bus_port_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic style_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire bus_port_pkg::byte_t data_host,
  input wire logic data_host_oe,
  input wire bus_port_pkg::byte_t data_dev,
  input wire logic data_dev_oe,
  input wire logic chan_a_irq_out,
  input wire logic chan_a_irq_oe,
  input wire logic chan_b_irq_out,
  input wire logic chan_c_irq_out,
  input wire logic chan_d_irq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  strobe_read_start_a: assert property (
    style_strobe && $fell(read_strobe_n) && !chan_a_select_n |-> ##[1:3] data_dev_oe)
    else $error("read strobe gave no data");
  strobe_read_cause_a: assert property (
    style_strobe && data_dev_oe |-> !$past(read_strobe_n)) else $error("data without strobe");
  strobe_write_quiet_a: assert property (
    style_strobe && $fell(write_strobe_n) |-> ##1 (!data_dev_oe)[*3])
    else $error("device drove during write");
  write_data_held_a: assert property (
    style_strobe && $rose(write_strobe_n) |-> data_host_oe && $stable(data_host))
    else $error("write data not held");
  rw_read_dir_a: assert property (
    !style_strobe && $fell(chan_a_select_n) && write_strobe_n |-> ##[1:3] data_dev_oe)
    else $error("rw read gave no data");
  read_data_stable_a: assert property (
    data_dev_oe && $past(data_dev_oe) |-> $stable(data_dev)) else $error("read data moved");
  rw_irq_low_a: assert property (
    !style_strobe && !$past(style_strobe) && chan_a_irq_oe |-> !chan_a_irq_out)
    else $error("open drain irq drove high");
  rw_irq_unused_a: assert property (
    (!style_strobe)[*2] |-> !chan_b_irq_out && !chan_c_irq_out && !chan_d_irq_out)
    else $error("unused irq not low");
endmodule // bus_port_props

// file: tb/quad_uart_host_bus_port_test.sv
// Random and corner traffic across both ends of the bus port
`timescale 1ns/1ns
module quad_uart_host_bus_port_test;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic style = 1'h1;
  logic req = 1'h0;
  logic req_write = 1'h0;
  logic [1:0] req_chan = 2'h0;
  logic [2:0] req_addr = 3'h0;
  bus_port_pkg::byte_t req_wdata = 8'h00;
  logic [3:0] chan_irq = 4'h0;
  logic busy, done, wr_commit, irq_pin;
  logic [1:0] wr_chan;
  logic [2:0] wr_addr;
  bus_port_pkg::byte_t rdata, wr_data;
  bus_port_pkg::byte_t mem [32];
  logic [12:0] wlast = 13'h0000;
  int fails = 0;
  int n_checks = 0;
  int seed = 85349;
  bus_port_if bif ();
  uart_bus_host u_uart_bus_host (.clk(clk), .sys_rst(sys_rst), .bus(bif), .style_strobe(style),
    .req(req), .req_write(req_write), .req_chan(req_chan), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
  uart_bus_port u_uart_bus_port (.clk(clk), .sys_rst(sys_rst), .bus(bif), .chan_irq(chan_irq),
    .wr_commit(wr_commit), .wr_chan(wr_chan), .wr_addr(wr_addr), .wr_data(wr_data));
  bus_port_props u_bus_port_props (.clk(clk), .sys_rst(sys_rst),
    .style_strobe(bif.style_strobe), .read_strobe_n(bif.read_strobe_n),
    .write_strobe_n(bif.write_strobe_n), .chan_a_select_n(bif.chan_a_select_n),
    .data_host(bif.data_host), .data_host_oe(bif.data_host_oe), .data_dev(bif.data_dev),
    .data_dev_oe(bif.data_dev_oe), .chan_a_irq_out(bif.chan_a_irq_out),
    .chan_a_irq_oe(bif.chan_a_irq_oe), .chan_b_irq_out(bif.chan_b_irq_out),
    .chan_c_irq_out(bif.chan_c_irq_out), .chan_d_irq_out(bif.chan_d_irq_out));
  // Board pull-up on the shared interrupt line
  assign irq_pin = bif.chan_a_irq_oe ? bif.chan_a_irq_out : 1'h1;
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_commit === 1'h1) begin
      wlast <= {wr_chan, wr_addr, wr_data};
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (e !== g) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // One host request, waited out and compared with the model
  task xfer(input logic w, input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
    int k;
    req <= 1'h1;
    req_write <= w;
    req_chan <= c;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'h0;
    k = 0;
    while (done !== 1'h1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 20) begin
      $display("unexpected done exp 1 got 0");
      fails++;
      test_done();
    end
    if (w) begin
      mem[{c, a}] = d;
      repeat (3) @(posedge clk);
      chk("write", {c, a, d}, wlast);
    end else begin
      chk("read", {c, a, mem[{c, a}]}, {c, a, rdata});
    end
    @(posedge clk);
  endtask
  // Expected {irq A enable, irq A pin, irq B, irq C, irq D} for requests v in style s
  function automatic logic [4:0] irq_exp(input logic s, input logic [3:0] v);
    logic [3:0] en;
    logic any;
    for (int c = 0; c < 4; c++) begin
      en[c] = mem[c*bus_port_pkg::REGS + bus_port_pkg::MODEM_CTRL_ADDR][bus_port_pkg::IRQ_EN_BIT];
    end
    any = |(v & en);
    irq_exp = s ? {en[0], v[0], v[1], v[2], v[3]} : {any, !any, 3'h0};
  endfunction
  task irq_chk(input logic [3:0] v);
    logic [4:0] seen;
    chan_irq <= v;
    repeat (3) @(posedge clk);
    #1;
    seen = {bif.chan_a_irq_oe, style ? bif.chan_a_irq_out : irq_pin, bif.chan_b_irq_out,
      bif.chan_c_irq_out, bif.chan_d_irq_out};
    chk("irq", {8'h00, irq_exp(style, v)}, {8'h00, seen});
    @(posedge clk);
  endtask
  initial begin
    int i;
    int s;
    logic [31:0] r;
    for (i = 0; i < 32; i++) begin
      mem[i] = 8'h00;
    end
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    for (s = 1; s >= 0; s--) begin
      style <= s[0];
      @(posedge clk);
      for (i = 0; i < 4; i++) begin
        xfer(1'h1, i[1:0], 3'h4, 8'h08);
      end
      irq_chk(4'h5);
      for (i = 0; i < 80; i++) begin
        r = $random(seed);
        xfer(r[0], r[2:1], r[5:3], r[13:6]);
        if (i % 10 == 0) begin
          irq_chk(r[17:14]);
        end
      end
      xfer(1'h1, 2'h0, 3'h4, 8'h00);
      irq_chk(4'hf);
    end
    test_done();
  end
endmodule // quad_uart_host_bus_port_test
